// ### src/vic_top.sv
// vectored interrupt controller: flags, enables, priorities, vector base
// assumes the core acks one cycle pulse on entry and on return from service
`timescale 1ns/1ps
module vic_top
  import vic_pkg::*;
(
  input wire logic CLK_SYS, // system clock
  input wire logic RSTN, // synchronous reset, active low
  input wire logic [vic_pkg::AW-1:0] ADDR, // register address
  input wire logic [vic_pkg::DW-1:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  output logic [vic_pkg::DW-1:0] RDATA, // read data, cycle after RD
  input wire logic [vic_pkg::NSRC-1:0] SRC_IRQ, // source events
  input wire logic [vic_pkg::DW-1:0] CONFIG_WORD_LOW, // config word
  input wire logic CORE_ACK, // core enters service
  input wire logic CORE_RETURN, // core returns from service
  input wire logic CORE_SLEEP, // core is asleep
  output logic CORE_IRQ, // single request to core
  output logic CORE_IRQ_HIGH, // request is high level
  output logic [vic_pkg::VAW-1:0] CORE_VECTOR, // vector address
  output logic CORE_WAKE // wake core from sleep
);
  import vic_pkg::*;

  // -------------------------------------------------------------
  // source synchroniser and register state
  // -------------------------------------------------------------
  logic [NSRC-1:0] src_meta;
  logic [NSRC-1:0] src_sync;
  logic [DW-1:0] flags;
  logic [DW-1:0] enable;
  logic [DW-1:0] prio;
  logic gie_high;
  logic gie_low;
  logic [VAW-1:0] vbase;
  logic locked;
  logic lock_used;
  logic in_high;
  logic in_low;
  logic [IDXW-1:0] active_idx;
  logic multi_vec;
  logic lock_once;

  assign multi_vec = CONFIG_WORD_LOW[CFG_MULTI_VEC];
  assign lock_once = CONFIG_WORD_LOW[CFG_LOCK_ONCE];

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      src_meta <= '0;
      src_sync <= '0;
    end else begin
      src_meta <= SRC_IRQ;
      src_sync <= src_meta;
    end
  end

  // -------------------------------------------------------------
  // register writes
  // -------------------------------------------------------------
  logic wr_ctrl0;
  logic wr_flags;
  logic wr_en;
  logic wr_prio;
  logic wr_lock;
  logic wr_base;
  assign wr_ctrl0 = WR && ADDR == OFS_CTRL0;
  assign wr_flags = WR && ADDR == OFS_FLAGS;
  assign wr_en = WR && ADDR == OFS_ENABLE7;
  assign wr_prio = WR && ADDR == OFS_PRIO;
  assign wr_lock = WR && ADDR == OFS_LOCK;
  assign wr_base = WR && !locked &&
    (ADDR == OFS_VBASE_L || ADDR == OFS_VBASE_H || ADDR == OFS_VBASE_U);

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      flags <= RST_BYTE;
    end else if (wr_flags) begin
      // writing zero clears; a same-cycle event still sets
      flags <= (flags & WDATA) | src_sync;
    end else begin
      flags <= flags | src_sync;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      enable <= RST_BYTE;
    end else if (wr_en) begin
      enable <= WDATA & ENABLE7_IMPL;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      prio <= RST_BYTE;
    end else if (wr_prio) begin
      prio <= WDATA;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      gie_high <= 1'b0;
      gie_low <= 1'b0;
    end else if (wr_ctrl0) begin
      gie_high <= WDATA[CTRL0_GIE_HIGH];
      gie_low <= WDATA[CTRL0_GIE_LOW];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      vbase <= RST_VBASE;
    end else if (wr_base) begin
      unique case (ADDR)
        OFS_VBASE_L: vbase[7:0] <= WDATA;
        OFS_VBASE_H: vbase[15:8] <= WDATA;
        default: vbase[20:16] <= WDATA[4:0];
      endcase
    end
  end

  // once-only mode: after the first set the lock sticks until reset
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      locked <= 1'b0;
      lock_used <= 1'b0;
    end else if (wr_lock && !(lock_once && lock_used)) begin
      locked <= WDATA[LOCK_BIT];
      lock_used <= lock_used | WDATA[LOCK_BIT];
    end
  end

  // -------------------------------------------------------------
  // arbitration per level
  // -------------------------------------------------------------
  logic [DW-1:0] pend;
  vic_arb_if #(.N(NSRC), .W(IDXW)) hi_if ();
  vic_arb_if #(.N(NSRC), .W(IDXW)) lo_if ();
  assign pend = flags & enable;
  assign hi_if.req = pend & prio;
  assign lo_if.req = pend & ~prio;
  vic_arbiter #(.N(NSRC), .W(IDXW)) u_arb_hi (.port(hi_if));
  vic_arbiter #(.N(NSRC), .W(IDXW)) u_arb_lo (.port(lo_if));

  logic go_high;
  logic go_low;
  logic [IDXW-1:0] win_idx;
  logic [VAW-1:0] next_vector;
  assign go_high = hi_if.valid && gie_high && !in_high;
  assign go_low = lo_if.valid && gie_low && !in_high && !in_low
    && !hi_if.valid;
  assign win_idx = go_high ? hi_if.idx : lo_if.idx;
  assign next_vector = multi_vec ?
    vbase + {{(VAW-IDXW-1){1'b0}}, win_idx, 1'b0} : LEGACY_VECTOR;

  // -------------------------------------------------------------
  // core request, registered for a fixed latency
  // -------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      CORE_IRQ <= 1'b0;
      CORE_IRQ_HIGH <= 1'b0;
      CORE_VECTOR <= LEGACY_VECTOR;
      CORE_WAKE <= 1'b0;
    end else begin
      CORE_IRQ <= (go_high || go_low) && !CORE_ACK;
      CORE_IRQ_HIGH <= go_high;
      CORE_VECTOR <= next_vector;
      CORE_WAKE <= CORE_SLEEP && |pend;
    end
  end

  // -------------------------------------------------------------
  // service level state
  // -------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      in_high <= 1'b0;
      in_low <= 1'b0;
      active_idx <= '0;
    end else if (CORE_ACK && CORE_IRQ) begin
      if (CORE_IRQ_HIGH) begin
        in_high <= 1'b1;
      end else begin
        in_low <= 1'b1;
      end
      active_idx <= CORE_VECTOR[IDXW:1] - vbase[IDXW:1];
    end else if (CORE_RETURN) begin
      if (in_high) begin
        in_high <= 1'b0;
      end else begin
        in_low <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // register reads
  // -------------------------------------------------------------
  logic [DW-1:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    unique case (ADDR)
      OFS_CTRL0: next_rdata = {gie_high, gie_low, 6'h00};
      OFS_CTRL1: next_rdata = {in_high, in_low, 6'h00};
      OFS_FLAGS: next_rdata = flags;
      OFS_ENABLE7: next_rdata = enable & ENABLE7_IMPL;
      OFS_PRIO: next_rdata = prio;
      OFS_VBASE_L: next_rdata = vbase[7:0];
      OFS_VBASE_H: next_rdata = vbase[15:8];
      OFS_VBASE_U: next_rdata = {3'h0, vbase[20:16]};
      OFS_LOCK: next_rdata = {7'h00, locked};
      OFS_ACTIVE: next_rdata = {5'h00, active_idx};
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      RDATA <= RST_BYTE;
    end else begin
      RDATA <= RD ? next_rdata : RST_BYTE;
    end
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  flag_set_a: assert property (
    (src_sync != 0) |=> ((flags & $past(src_sync)) == $past(src_sync)))
    else $error("event did not set its flag");
  flag_hold_a: assert property (
    !wr_flags |=> ((flags & $past(flags)) == $past(flags)))
    else $error("flag cleared without a write");
  latency_a: assert property (
    $rose(src_sync[0]) && enable[0] && prio[0] && gie_high && !in_high
    && !CORE_ACK && !wr_en && !wr_prio && !wr_ctrl0 && !CORE_RETURN
    |-> ##2 CORE_IRQ && CORE_IRQ_HIGH)
    else $error("request latency is not fixed");
  enable_gate_a: assert property (
    CORE_IRQ |-> ($past(flags & enable) != 0))
    else $error("request without enabled flag");
  base_lock_a: assert property (
    locked && WR |=> $stable(vbase))
    else $error("locked base was written");
  unimpl_zero_a: assert property (
    (enable & ~ENABLE7_IMPL) == 0)
    else $error("unimplemented enable bit set");
  low_wait_a: assert property (
    CORE_IRQ && !CORE_IRQ_HIGH |-> $past(!in_high && !in_low))
    else $error("low request during service");
  high_first_a: assert property (
    hi_if.valid && gie_high && !in_high && !CORE_ACK |=> CORE_IRQ_HIGH)
    else $error("high level did not win");
  vector_a: assert property (
    CORE_IRQ && $past(multi_vec) |->
    CORE_VECTOR == $past(vbase) + {{(VAW-IDXW-1){1'b0}}, $past(win_idx), 1'b0})
    else $error("wrong vector address");
  legacy_vec_a: assert property (
    CORE_IRQ && !$past(multi_vec) |-> CORE_VECTOR == LEGACY_VECTOR)
    else $error("single vector not 0004h");
  lock_once_a: assert property (
    lock_once && lock_used |=> locked || !$past(locked))
    else $error("once-only lock was cleared");
  status_a: assert property (
    RD && ADDR == OFS_CTRL1 |=> RDATA[CTRL1_IN_HIGH] == $past(in_high))
    else $error("status bit wrong");

  nest_c: cover property (in_low ##[1:20] in_high && in_low);
  wake_c: cover property (CORE_SLEEP && !gie_high ##1 CORE_WAKE);
  locked_c: cover property (locked && wr_base == 1'b0 && WR);
  low_c: cover property (CORE_IRQ && !CORE_IRQ_HIGH);
endmodule

// ### src/vic_pkg.sv
// vectored interrupt controller: register map, field positions, reset values
// assumes an 8-bit register port and one system clock
package vic_pkg;
  localparam int NSRC = 8;
  localparam int IDXW = 3;
  localparam int DW = 8;
  localparam int AW = 4;
  localparam int VAW = 21;
  // -------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------
  localparam logic [AW-1:0] OFS_CTRL0 = 4'h0;
  localparam logic [AW-1:0] OFS_CTRL1 = 4'h1;
  localparam logic [AW-1:0] OFS_FLAGS = 4'h2;
  localparam logic [AW-1:0] OFS_ENABLE7 = 4'h3;
  localparam logic [AW-1:0] OFS_PRIO = 4'h4;
  localparam logic [AW-1:0] OFS_VBASE_L = 4'h5;
  localparam logic [AW-1:0] OFS_VBASE_H = 4'h6;
  localparam logic [AW-1:0] OFS_VBASE_U = 4'h7;
  localparam logic [AW-1:0] OFS_LOCK = 4'h8;
  localparam logic [AW-1:0] OFS_ACTIVE = 4'h9;
  // -------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------
  localparam int CTRL0_GIE_HIGH = 7;
  localparam int CTRL0_GIE_LOW = 6;
  localparam int CTRL1_IN_HIGH = 7;
  localparam int CTRL1_IN_LOW = 6;
  localparam int LOCK_BIT = 0;
  localparam int CFG_MULTI_VEC = 3;
  localparam int CFG_LOCK_ONCE = 4;
  // enable register 7: bits 5,4,3,1,0 implemented
  localparam logic [DW-1:0] ENABLE7_IMPL = 8'h3b;
  // -------------------------------------------------------------
  // reset values and fixed addresses
  // -------------------------------------------------------------
  localparam logic [DW-1:0] RST_BYTE = 8'h00;
  localparam logic [VAW-1:0] RST_VBASE = 21'h000008;
  localparam logic [VAW-1:0] LEGACY_VECTOR = 21'h000004;
  localparam int LATENCY_CYCLES = 2;
endpackage

// ### src/vic_arb_if.sv
// request vector and winner of one priority level
// assumes the arbiter is purely combinational
`timescale 1ns/1ps
interface vic_arb_if #(parameter int N = 8, parameter int W = 3);
  logic [N-1:0] req;
  logic valid;
  logic [W-1:0] idx;
  modport arb (input req, output valid, output idx);
  modport user (output req, input valid, input idx);
endinterface

// ### src/vic_arbiter.sv
// fixed-order arbiter: lowest table position wins
// assumes request bits are already masked by enable and level
`timescale 1ns/1ps
module vic_arbiter #(parameter int N = 8, parameter int W = 3) (
  vic_arb_if.arb port // requests in, winner out
);
  initial begin
    if (N < 1 || N > (1 << W)) begin
      $error("vic_arbiter: N does not fit index width");
    end
  end
  always_comb begin
    port.valid = 1'b0;
    port.idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (port.req[i]) begin
        port.valid = 1'b1;
        port.idx = W'(i);
      end
    end
  end
endmodule

// ### test/vic_core_model.sv
// core model: takes the single request from the controller with an entry pulse
// assumes the request is a registered level that drops after the entry pulse
`timescale 1ns/1ps
module vic_core_model (
  input wire logic clk, // system clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic irq, // request from the controller
  input wire logic accept, // core is willing to enter service
  input wire logic ret, // return from service
  output logic ack // entry pulse, one cycle
);
  // ----------------------------------------------------------
  // entry pulse
  // ----------------------------------------------------------
  // one pulse per request; never beside a return so the level state stays clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ack <= 1'b0;
    end else begin
      ack <= irq && accept && !ack && !ret;
    end
  end
endmodule

// ### test/vic_top_test.sv
// self-checking bench: register port, source events, nesting, wake, lock
// assumes the controller answers reads one cycle after the strobe
`timescale 1ns/1ps
module vic_top_test;
  import vic_pkg::*;
  logic clk, rstn, wr, rd, sleep, ret, accept, irq, irq_high, wake, ack;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata, cfg, pr, m;
  logic [NSRC-1:0] src;
  logic [VAW-1:0] vec, base;
  int n_fail, checks, seed, cyc, lat, lat0, i;
  int srcs[5] = '{0, 1, 3, 4, 5};
  vic_top i_vic_top (.CLK_SYS(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .SRC_IRQ(src), .CONFIG_WORD_LOW(cfg), .CORE_ACK(ack),
    .CORE_RETURN(ret), .CORE_SLEEP(sleep), .CORE_IRQ(irq), .CORE_IRQ_HIGH(irq_high),
    .CORE_VECTOR(vec), .CORE_WAKE(wake));
  vic_core_model i_vic_core_model (.clk(clk), .rstn(rstn), .irq(irq), .accept(accept),
    .ret(ret), .ack(ack));
  // ----------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------
  task automatic report_and_stop;
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [VAW-1:0] got, input logic [VAW-1:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [AW-1:0] ad, input logic [DW-1:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [AW-1:0] ad, input logic [DW-1:0] exp);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({13'h0, rdata}, {13'h0, exp});
  endtask
  // one-cycle event, then count cycles until the core sees a request
  task automatic fire(input logic [NSRC-1:0] e);
    @(posedge clk);
    src <= e;
    @(posedge clk);
    src <= '0;
    lat = 1;
    #1;
    while (irq !== 1'b1 && lat < 12) begin
      @(posedge clk);
      #1;
      lat++;
    end
  endtask
  task automatic pulse_ret;
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
  endtask
  // high level first, then lowest table position
  function automatic int exp_win(input logic [NSRC-1:0] q, input logic [NSRC-1:0] p);
    exp_win = 0;
    for (int k = NSRC - 1; k >= 0; k--) if (q[k] && !p[k]) exp_win = k;
    for (int k = NSRC - 1; k >= 0; k--) if (q[k] && p[k]) exp_win = k;
  endfunction
  // ----------------------------------------------------------
  // clock, timeout, main sequence
  // ----------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop;
    end
  end
  initial begin
    seed = 8;
    {rstn, wr, rd, sleep, ret, addr, wdata, src} = '0;
    cfg = 8'h08;
    accept = 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int r = 0; r < 9; r++) rd_chk(r[AW-1:0], (r == 5) ? 8'h08 : 8'h00);
    rd_chk(4'hf, 8'h00);
    chk(vec, RST_VBASE);
    wr_reg(OFS_ENABLE7, 8'hc4);
    rd_chk(OFS_ENABLE7, 8'h00);
    wr_reg(OFS_ENABLE7, 8'hff);
    rd_chk(OFS_ENABLE7, 8'h3b);
    base = 21'($random(seed)) & 21'h1fffff;
    wr_reg(OFS_VBASE_L, base[7:0]);
    wr_reg(OFS_VBASE_H, base[15:8]);
    wr_reg(OFS_VBASE_U, {3'h7, base[20:16]});
    rd_chk(OFS_VBASE_U, {3'h0, base[20:16]});
    wr_reg(OFS_CTRL0, 8'hc0);
    pr = 8'($random(seed));
    wr_reg(OFS_PRIO, pr);
    for (int k = 0; k < 5; k++) begin
      i = srcs[k];
      fire(NSRC'(1 << i));
      if (k == 0) lat0 = lat;
      chk(lat[VAW-1:0], lat0[VAW-1:0]);
      chk(vec, base + 21'(2 * i));
      chk({20'h0, irq_high}, {20'h0, pr[i]});
      rd_chk(OFS_FLAGS, 8'(1 << i));
      wr_reg(OFS_FLAGS, 8'h00);
      rd_chk(OFS_FLAGS, 8'h00);
      chk({20'h0, irq}, 21'h0);
    end
    for (int k = 0; k < 7; k++) begin
      pr = (k == 0) ? 8'h20 : 8'($random(seed));
      m = (k == 0) ? 8'h3b : 8'($random(seed)) & 8'h3b;
      wr_reg(OFS_PRIO, pr);
      fire(m);
      chk(vec, base + 21'(2 * exp_win(m, pr)));
      wr_reg(OFS_FLAGS, 8'h00);
    end
    wr_reg(OFS_ENABLE7, 8'h02);
    fire(8'h01);
    chk({20'h0, irq}, 21'h0);
    wr_reg(OFS_FLAGS, 8'h00);
    wr_reg(OFS_ENABLE7, 8'hff);
    wr_reg(OFS_PRIO, 8'h01);
    accept <= 1'b1;
    fire(8'h02);
    repeat (3) @(posedge clk);
    rd_chk(OFS_CTRL1, 8'h40);
    rd_chk(OFS_ACTIVE, 8'h01);
    accept <= 1'b0;
    fire(8'h08);
    chk({20'h0, irq}, 21'h0);
    fire(8'h01);
    chk({20'h0, irq_high}, 21'h1);
    accept <= 1'b1;
    repeat (3) @(posedge clk);
    accept <= 1'b0;
    rd_chk(OFS_CTRL1, 8'hc0);
    rd_chk(OFS_ACTIVE, 8'h00);
    wr_reg(OFS_FLAGS, 8'h08);
    pulse_ret;
    rd_chk(OFS_CTRL1, 8'h40);
    pulse_ret;
    repeat (3) @(posedge clk);
    chk(vec, base + 21'h6);
    chk({20'h0, irq}, 21'h1);
    wr_reg(OFS_FLAGS, 8'h00);
    wr_reg(OFS_CTRL0, 8'h00);
    cfg <= 8'h00;
    sleep <= 1'b1;
    fire(8'h10);
    chk({20'h0, wake}, 21'h1);
    chk({20'h0, irq}, 21'h0);
    wr_reg(OFS_CTRL0, 8'hc0);
    repeat (3) @(posedge clk);
    chk(vec, LEGACY_VECTOR);
    wr_reg(OFS_FLAGS, 8'h00);
    sleep <= 1'b0;
    wr_reg(OFS_LOCK, 8'h01);
    wr_reg(OFS_LOCK, 8'h00);
    rd_chk(OFS_LOCK, 8'h00);
    // once-only counts every set since reset, so start that case from a fresh reset
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    cfg <= 8'h18;
    rd_chk(OFS_CTRL0, 8'h00);
    wr_reg(OFS_LOCK, 8'h01);
    wr_reg(OFS_VBASE_L, ~RST_VBASE[7:0]);
    rd_chk(OFS_VBASE_L, RST_VBASE[7:0]);
    wr_reg(OFS_LOCK, 8'h00);
    rd_chk(OFS_LOCK, 8'h01);
    report_and_stop;
  end
endmodule
